// File: mcs_core.v
`timescale 1ns/1ps
`default_nettype none
`include "mcs_defs.vh"
module mcs_core (
  input wire CLK,
  input wire RESET,
  // AXI4-Lite slave
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  // Events from command/data engines (same clock)
  input wire CMD_START,
  input wire RESP_RCVD,
  input wire CMD_SENT,
  input wire RESP_CRC_ERR,
  input wire READ_START,
  input wire READ_DATA_ARRIVED,
  input wire READ_CRC_ERR,
  input wire WRITE_CRC_ERR,
  input wire DATA_COMPLETE,
  input wire BLOCK_DONE,
  input wire BYTE_TO_SHIFTER,
  input wire XFER_ACTIVE,
  input wire TX_SHIFTER_EMPTY,
  input wire STOP_CMD,
  input wire [7:0] FIFO_LEVEL,
  input wire [31:0] FIFO_RDATA,
  // Busy indication from card pin
  input wire CARD_BUSY_PIN,
  // Outputs
  output reg CARD_CLOCK_PIN,
  output reg BUS_4BIT,
  output reg CMD_LOGIC_RESET,
  output reg DATA_LOGIC_RESET,
  output reg RESP_TIMEOUT,
  output reg READ_TIMEOUT,
  output reg XFER_LAST_BLOCK,
  output reg FIFO_POP,
  output reg FIFO_PUSH,
  output reg [31:0] FIFO_WDATA,
  output reg IRQ
);
  // ==========================================================
  // Registers
  reg [7:0] control_reg_r;
  reg [9:0] clock_ctrl_reg_r;
  reg [12:0] interrupt_mask_reg_r;
  reg [7:0] response_timeout_reg_r;
  reg [15:0] read_timeout_reg_r;
  reg [11:0] block_length_reg_r;
  reg [15:0] block_count_reg_r;
  reg [15:0] blocks_left_r;
  reg [2:0] fifo_ctrl_reg_r;
  reg [1:0] command_reg_r;
  reg [12:0] status_reg_a_r;
  reg [12:0] stat_set;
  reg [11:0] byte_cnt_r;
  reg busy_wait_r;
  reg resp_wait_r;
  reg read_wait_r;
  reg busy_s1_r;
  reg busy_s2_r;
  reg have_aw_r;
  reg have_w_r;
  reg [7:0] aw_r;
  reg [31:0] w_r;
  wire mclk;
  wire mrise;
  wire to_resp;
  wire to_read;
  wire ctl_rst = control_reg_r[`MCS_CTL_CMD_LOGIC_RESET] | control_reg_r[`MCS_CTL_DATA_LOGIC_RESET];
  wire wr_go = have_aw_r & have_w_r & ~BVALID;
  wire rd_go = ARREADY & ARVALID;
  wire rd_sta = rd_go & (ARADDR == `MCS_OFF_STA);
  wire [7:0] thresh = fifo_ctrl_reg_r[0] ? `MCS_THR_HI : `MCS_THR_LO;
  wire last_byte = BYTE_TO_SHIFTER & (byte_cnt_r == block_length_reg_r - 12'h001)
    & (block_count_reg_r != 16'h0000) & (blocks_left_r == 16'h0001);

  // ==========================================================
  // Clock divider and time-out counters
  mcs_clkdiv u_div (
    .CLK(CLK),
    .RESET(RESET),
    .div(clock_ctrl_reg_r[7:0]),
    .divide_by_four(clock_ctrl_reg_r[`MCS_CLK_DIVIDE_BY_FOUR]),
    .run(~ctl_rst),
    .mclk_r(mclk),
    .rise_r(mrise)
  );
  mcs_tocnt #(.W(8)) u_tor (
    .CLK(CLK),
    .RESET(RESET),
    .start(CMD_START & ~ctl_rst),
    .waiting(resp_wait_r),
    .tick(mrise),
    .limit(response_timeout_reg_r),
    .expire_r(to_resp)
  );
  mcs_tocnt #(.W(16)) u_tod (
    .CLK(CLK),
    .RESET(RESET),
    .start(READ_START & ~ctl_rst),
    .waiting(read_wait_r),
    .tick(mrise),
    .limit(read_timeout_reg_r),
    .expire_r(to_read)
  );

  // ==========================================================
  // Card busy pin synchroniser
  always @(posedge CLK) begin
    if (RESET) begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
    end else begin
      busy_s1_r <= CARD_BUSY_PIN;
      busy_s2_r <= busy_s1_r;
    end
  end

  // ==========================================================
  // Event collection for status A
  always @* begin
    stat_set = {`MCS_NFLAG{1'b0}};
    stat_set[`MCS_ST_RXRDY] = FIFO_LEVEL > thresh;
    stat_set[`MCS_ST_TXRDY] = XFER_ACTIVE & (FIFO_LEVEL < thresh);
    stat_set[`MCS_ST_RESP_CRC_ERR] = RESP_CRC_ERR;
    stat_set[`MCS_ST_READ_CRC_ERR] = READ_CRC_ERR;
    stat_set[`MCS_ST_WRITE_CRC_ERR] = WRITE_CRC_ERR;
    stat_set[`MCS_ST_TORESP] = to_resp;
    stat_set[`MCS_ST_TORD] = to_read;
    stat_set[`MCS_ST_RSPDONE] = RESP_RCVD | (CMD_SENT & command_reg_r[`MCS_CMD_NORESP]);
    stat_set[`MCS_ST_BSYDONE] = busy_wait_r & ~busy_s2_r;
    stat_set[`MCS_ST_DATDONE] = DATA_COMPLETE;
    stat_set[`MCS_ST_LAST] = last_byte;
    if (ctl_rst) begin
      stat_set = {`MCS_NFLAG{1'b0}};
    end
  end

  // ==========================================================
  // Sticky status, wait tracking, block counting
  // Set wins over a clear by status read or receive-data read
  always @(posedge CLK) begin
    if (RESET) begin
      status_reg_a_r <= {`MCS_NFLAG{1'b0}};
      busy_wait_r <= 1'b0;
      resp_wait_r <= 1'b0;
      read_wait_r <= 1'b0;
      byte_cnt_r <= 12'h000;
      blocks_left_r <= 16'h0000;
    end else begin
      if (rd_sta) begin
        status_reg_a_r <= stat_set;
      end else if (rd_go && ARADDR == `MCS_OFF_RXD) begin
        status_reg_a_r <= (status_reg_a_r & ~(13'h0001 << `MCS_ST_RXRDY)) | stat_set;
      end else begin
        status_reg_a_r <= status_reg_a_r | stat_set;
      end
      if (ctl_rst) begin
        resp_wait_r <= 1'b0;
        read_wait_r <= 1'b0;
        busy_wait_r <= 1'b0;
      end else begin
        if (CMD_START) begin
          resp_wait_r <= ~command_reg_r[`MCS_CMD_NORESP];
        end else if (RESP_RCVD || to_resp) begin
          resp_wait_r <= 1'b0;
        end
        if (READ_START) begin
          read_wait_r <= 1'b1;
        end else if (READ_DATA_ARRIVED || to_read) begin
          read_wait_r <= 1'b0;
        end
        if (RESP_RCVD || CMD_SENT) begin
          busy_wait_r <= command_reg_r[`MCS_CMD_BUSY];
        end else if (!busy_s2_r) begin
          busy_wait_r <= 1'b0;
        end
      end
      // Byte and block accounting
      if (ctl_rst || CMD_START) begin
        byte_cnt_r <= 12'h000;
        blocks_left_r <= block_count_reg_r;
      end else if (BYTE_TO_SHIFTER) begin
        if (byte_cnt_r == block_length_reg_r - 12'h001) begin
          byte_cnt_r <= 12'h000;
          if (blocks_left_r != 16'h0000) begin
            blocks_left_r <= blocks_left_r - 16'h0001;
          end
        end else begin
          byte_cnt_r <= byte_cnt_r + 12'h001;
        end
      end
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  always @(posedge CLK) begin
    if (RESET) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      have_aw_r <= 1'b0;
      have_w_r <= 1'b0;
      aw_r <= 8'h00;
      w_r <= 32'h00000000;
      BVALID <= 1'b0;
      BRESP <= `MCS_RESP_OK;
      control_reg_r <= `MCS_RST_CTRL;
      clock_ctrl_reg_r <= `MCS_RST_CLK;
      interrupt_mask_reg_r <= {`MCS_NFLAG{1'b0}};
      response_timeout_reg_r <= 8'h00;
      read_timeout_reg_r <= 16'h0000;
      block_length_reg_r <= `MCS_RST_BLEN;
      block_count_reg_r <= 16'h0000;
      fifo_ctrl_reg_r <= 3'h0;
      command_reg_r <= 2'h0;
      FIFO_PUSH <= 1'b0;
      FIFO_WDATA <= 32'h00000000;
    end else begin
      FIFO_PUSH <= 1'b0;
      if (AWREADY && AWVALID) begin
        aw_r <= AWADDR;
        have_aw_r <= 1'b1;
        AWREADY <= 1'b0;
      end
      if (WREADY && WVALID) begin
        w_r <= WDATA;
        have_w_r <= 1'b1;
        WREADY <= 1'b0;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
      // Byte strobes ignored: every register is written whole
      if (wr_go) begin
        have_aw_r <= 1'b0;
        have_w_r <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= `MCS_RESP_OK;
        case (aw_r)
          `MCS_OFF_CTRL: control_reg_r <= w_r[7:0];
          `MCS_OFF_CLK: clock_ctrl_reg_r <= w_r[9:0];
          `MCS_OFF_IM: interrupt_mask_reg_r <= w_r[12:0];
          `MCS_OFF_TOR: response_timeout_reg_r <= w_r[7:0];
          `MCS_OFF_TOD: read_timeout_reg_r <= w_r[15:0];
          `MCS_OFF_BLEN: block_length_reg_r <= w_r[11:0];
          `MCS_OFF_NBLK: block_count_reg_r <= w_r[15:0];
          `MCS_OFF_FIFO: fifo_ctrl_reg_r <= w_r[2:0];
          `MCS_OFF_CMD: command_reg_r <= w_r[1:0];
          `MCS_OFF_TXD: begin
            FIFO_PUSH <= 1'b1;
            FIFO_WDATA <= w_r;
          end
          default: BRESP <= `MCS_RESP_SLVERR;
        endcase
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel, one cycle after address
  always @(posedge CLK) begin
    if (RESET) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `MCS_RESP_OK;
      FIFO_POP <= 1'b0;
    end else begin
      FIFO_POP <= 1'b0;
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
      if (rd_go) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RRESP <= `MCS_RESP_OK;
        RDATA <= 32'h00000000;
        case (ARADDR)
          `MCS_OFF_CTRL: RDATA <= {24'h000000, control_reg_r};
          `MCS_OFF_CLK: RDATA <= {22'h000000, clock_ctrl_reg_r};
          `MCS_OFF_STA: RDATA <= {19'h00000, status_reg_a_r};
          `MCS_OFF_STB: RDATA <= {25'h0000000, ~CARD_CLOCK_PIN & ~clock_ctrl_reg_r[`MCS_CLK_EN],
            2'h0, TX_SHIFTER_EMPTY, 2'h0, busy_s2_r};
          `MCS_OFF_IM: RDATA <= {19'h00000, interrupt_mask_reg_r};
          `MCS_OFF_TOR: RDATA <= {24'h000000, response_timeout_reg_r};
          `MCS_OFF_TOD: RDATA <= {16'h0000, read_timeout_reg_r};
          `MCS_OFF_BLEN: RDATA <= {20'h00000, block_length_reg_r};
          `MCS_OFF_NBLK: RDATA <= {16'h0000, block_count_reg_r};
          `MCS_OFF_NBLC: RDATA <= {16'h0000, blocks_left_r};
          `MCS_OFF_FIFO: RDATA <= {29'h00000000, fifo_ctrl_reg_r};
          `MCS_OFF_CMD: RDATA <= {30'h00000000, command_reg_r};
          `MCS_OFF_RXD: begin
            RDATA <= FIFO_RDATA;
            FIFO_POP <= 1'b1;
          end
          `MCS_OFF_TXD: RDATA <= 32'h00000000;
          default: RRESP <= `MCS_RESP_SLVERR;
        endcase
      end
    end
  end

  // ==========================================================
  // Registered outputs: card clock gate, mode, time-outs, interrupt
  // Plain AND gate: an enable drop mid-high can shorten one card clock pulse
  always @(posedge CLK) begin
    if (RESET) begin
      CARD_CLOCK_PIN <= 1'b0;
      BUS_4BIT <= 1'b0;
      CMD_LOGIC_RESET <= 1'b1;
      DATA_LOGIC_RESET <= 1'b1;
      RESP_TIMEOUT <= 1'b0;
      READ_TIMEOUT <= 1'b0;
      XFER_LAST_BLOCK <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      CARD_CLOCK_PIN <= mclk & (clock_ctrl_reg_r[`MCS_CLK_EN]
        | XFER_ACTIVE | resp_wait_r | busy_wait_r);
      BUS_4BIT <= control_reg_r[`MCS_CTL_WIDTH];
      CMD_LOGIC_RESET <= control_reg_r[`MCS_CTL_CMD_LOGIC_RESET];
      DATA_LOGIC_RESET <= control_reg_r[`MCS_CTL_DATA_LOGIC_RESET];
      RESP_TIMEOUT <= to_resp;
      READ_TIMEOUT <= to_read;
      // Unlimited count never flags a last block; STOP_CMD masks it only while high
      XFER_LAST_BLOCK <= (block_count_reg_r != 16'h0000)
        & (blocks_left_r == 16'h0001) & ~STOP_CMD;
      IRQ <= |(status_reg_a_r & interrupt_mask_reg_r);
    end
  end
endmodule
`default_nettype wire

// File: mcs_defs.vh
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH
// ==========================================================
// Register byte offsets
`define MCS_OFF_CTRL 8'h00
`define MCS_OFF_CLK 8'h04
`define MCS_OFF_STA 8'h08
`define MCS_OFF_STB 8'h0C
`define MCS_OFF_IM 8'h10
`define MCS_OFF_TOR 8'h14
`define MCS_OFF_TOD 8'h18
`define MCS_OFF_BLEN 8'h1C
`define MCS_OFF_NBLK 8'h20
`define MCS_OFF_FIFO 8'h24
`define MCS_OFF_RXD 8'h28
`define MCS_OFF_TXD 8'h2C
`define MCS_OFF_CMD 8'h30
`define MCS_OFF_NBLC 8'h34
// ==========================================================
// Control register fields
`define MCS_CTL_CMD_LOGIC_RESET 0
`define MCS_CTL_DATA_LOGIC_RESET 1
`define MCS_CTL_WIDTH 2
// Clock register fields
`define MCS_CLK_EN 8
`define MCS_CLK_DIVIDE_BY_FOUR 9
// Command register fields
`define MCS_CMD_BUSY 0
`define MCS_CMD_NORESP 1
// Status A flag positions (mask uses the same)
`define MCS_ST_DATDONE 0
`define MCS_ST_BSYDONE 1
`define MCS_ST_RSPDONE 2
`define MCS_ST_TORESP 3
`define MCS_ST_TORD 4
`define MCS_ST_WRITE_CRC_ERR 5
`define MCS_ST_READ_CRC_ERR 6
`define MCS_ST_RESP_CRC_ERR 7
`define MCS_ST_TXRDY 9
`define MCS_ST_RXRDY 10
`define MCS_ST_LAST 12
`define MCS_NFLAG 13
// Status B fields
`define MCS_SB_BUSY 0
`define MCS_SB_TXEMP 3
`define MCS_SB_CLKSTP 6
// Reset values
`define MCS_RST_CTRL 8'h03
`define MCS_RST_BLEN 12'h200
`define MCS_RST_CLK 10'h0FF
// FIFO thresholds in bytes
`define MCS_THR_HI 8'h40
`define MCS_THR_LO 8'h20
// AXI responses
`define MCS_RESP_OK 2'h0
`define MCS_RESP_SLVERR 2'h2
`endif

// File: mcs_clkdiv.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Memory clock divider: toggles every (div+1)*(1 or 2) cycles
module mcs_clkdiv (
  input wire CLK,
  input wire RESET,
  input wire [7:0] div,
  input wire divide_by_four,
  input wire run,
  output reg mclk_r,
  output reg rise_r
);
  reg [8:0] cnt_r;
  wire [8:0] half = divide_by_four ? {div, 1'b1} : {1'b0, div};
  // Half period of (div+1) or 2*(div+1) cycles
  always @(posedge CLK) begin
    if (RESET) begin
      cnt_r <= 9'h000;
      mclk_r <= 1'b0;
      rise_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= 9'h000;
      mclk_r <= 1'b0;
      rise_r <= 1'b0;
    end else if (cnt_r >= half) begin
      cnt_r <= 9'h000;
      mclk_r <= ~mclk_r;
      rise_r <= ~mclk_r;
    end else begin
      cnt_r <= cnt_r + 9'h001;
      rise_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: mcs_tocnt.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Time-out counter in memory clock cycles; zero limit waits forever
module mcs_tocnt #(
  parameter W = 16
) (
  input wire CLK,
  input wire RESET,
  input wire start,
  input wire waiting,
  input wire tick,
  input wire [W-1:0] limit,
  output reg expire_r
);
  reg [W-1:0] cnt_r;
  reg armed_r;
  always @(posedge CLK) begin
    if (RESET) begin
      cnt_r <= {W{1'b0}};
      armed_r <= 1'b0;
      expire_r <= 1'b0;
    end else begin
      expire_r <= 1'b0;
      if (start) begin
        cnt_r <= limit;
        armed_r <= (limit != {W{1'b0}});
      end else if (!waiting) begin
        armed_r <= 1'b0;
      end else if (armed_r && tick) begin
        if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
          expire_r <= 1'b1;
          armed_r <= 1'b0;
        end
        cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// File: mcs_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checks for the configuration and status block
module mcs_core_properties (
  input wire CLK,
  input wire RESET,
  input wire AWVALID,
  input wire AWREADY,
  input wire WVALID,
  input wire WREADY,
  input wire [1:0] BRESP,
  input wire BVALID,
  input wire BREADY,
  input wire ARVALID,
  input wire ARREADY,
  input wire [31:0] RDATA,
  input wire RVALID,
  input wire RREADY,
  input wire CMD_START,
  input wire RESP_RCVD,
  input wire READ_START,
  input wire READ_DATA_ARRIVED,
  input wire BUS_4BIT,
  input wire CMD_LOGIC_RESET,
  input wire DATA_LOGIC_RESET,
  input wire RESP_TIMEOUT,
  input wire READ_TIMEOUT,
  input wire IRQ
);
  reg rwait_r;
  reg dwait_r;
  // Open waits; an expiry with no wait behind it means a stray count
  always @(posedge CLK) begin
    if (RESET) begin
      rwait_r <= 1'h0;
      dwait_r <= 1'h0;
    end else begin
      rwait_r <= CMD_START | (rwait_r & ~RESP_RCVD & ~RESP_TIMEOUT);
      dwait_r <= READ_START | (dwait_r & ~READ_DATA_ARRIVED & ~READ_TIMEOUT);
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // Reset state, seen on the first edge after release
  chk_reset_holds: assert property ($fell(RESET) |-> CMD_LOGIC_RESET && DATA_LOGIC_RESET)
    else $error("controller not held after reset");
  chk_width_reset: assert property ($fell(RESET) |-> !BUS_4BIT)
    else $error("bus width not one bit after reset");
  chk_irq_reset: assert property ($fell(RESET) |-> !IRQ)
    else $error("interrupt high after reset");
  // Response counter must stay quiet while held; both fire only inside a wait
  chk_to_held: assert property ((CMD_LOGIC_RESET || DATA_LOGIC_RESET) |-> !RESP_TIMEOUT)
    else $error("time-out while controller held");
  chk_resp_cause: assert property (RESP_TIMEOUT |-> rwait_r || $past(rwait_r))
    else $error("response time-out with no wait open");
  chk_read_cause: assert property (READ_TIMEOUT |-> dwait_r || $past(dwait_r, 1))
    else $error("read time-out with no wait open");
  // Bus answers and their holding
  chk_rd_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  chk_rd_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped before accepted");
  chk_wr_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
    else $error("write answer late");
  chk_wr_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before accepted");
  cov_resp_to: cover property (RESP_TIMEOUT);
  cov_read_to: cover property (READ_TIMEOUT);
  cov_irq: cover property ($rose(IRQ));
  cov_write: cover property (BVALID && BREADY);
endmodule

bind mcs_core mcs_core_properties u_props (
  .CLK, .RESET, .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
  .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY, .CMD_START, .RESP_RCVD, .READ_START,
  .READ_DATA_ARRIVED, .BUS_4BIT, .CMD_LOGIC_RESET, .DATA_LOGIC_RESET, .RESP_TIMEOUT,
  .READ_TIMEOUT, .IRQ);
`default_nettype wire

// File: mcs_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Card stand-in: signals busy in step with its own clock
module mcs_card_model (
  input wire logic card_clk,
  input wire logic busy_req,
  output var logic busy_o
);
  initial busy_o = 1'h0;
  // Busy moves only on card clock rises, so a stopped clock freezes it
  always @(posedge card_clk) begin
    busy_o <= busy_req;
  end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcs_defs.vh"
// ==========================================================
// Self-checking bench for the configuration and status block
module testbench;
  logic CLK = 1'h0;
  logic RESET = 1'h1;
  logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic xfer = 1'h0, txemp = 1'h0, busy_req = 1'h0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, FIFO_LEVEL = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [10:0] ev = 11'h000;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, busy, CARD_CLOCK_PIN, BUS_4BIT, IRQ;
  wire CMD_LOGIC_RESET, DATA_LOGIC_RESET, RESP_TIMEOUT, READ_TIMEOUT, XFER_LAST_BLOCK;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA, FIFO_WDATA;
  int failures = 0;
  int tests_run = 0;

  // 40 MHz function clock
  always #12.5 CLK = ~CLK;

  mcs_core u_dut (
    .CLK, .RESET, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB(4'hF), .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .CMD_START(ev[0]), .RESP_RCVD(ev[1]), .CMD_SENT(ev[2]), .RESP_CRC_ERR(ev[3]),
    .READ_START(ev[4]), .READ_DATA_ARRIVED(ev[5]), .READ_CRC_ERR(ev[6]),
    .WRITE_CRC_ERR(ev[7]), .DATA_COMPLETE(ev[8]), .BLOCK_DONE(1'h0), .BYTE_TO_SHIFTER(ev[9]),
    .XFER_ACTIVE(xfer), .TX_SHIFTER_EMPTY(txemp), .STOP_CMD(ev[10]), .FIFO_LEVEL,
    .FIFO_RDATA(32'h0), .CARD_BUSY_PIN(busy), .CARD_CLOCK_PIN, .BUS_4BIT, .CMD_LOGIC_RESET,
    .DATA_LOGIC_RESET, .RESP_TIMEOUT, .READ_TIMEOUT, .XFER_LAST_BLOCK, .FIFO_POP(),
    .FIFO_PUSH(), .FIFO_WDATA, .IRQ);

  mcs_card_model u_card (.card_clk(CARD_CLOCK_PIN), .busy_req, .busy_o(busy));

  task automatic results;
    begin
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      tests_run++;
      if (got !== exp) begin
        failures++;
        $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask

  // A wait that runs out ends the run
  task automatic lost(input string what);
    begin
      failures++;
      $display("[FAIL] %s expected answer seen none", what);
      results();
    end
  endtask

  // Bus master; ready raised late so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    begin
      n = 0;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      do begin
        @(posedge CLK);
        n++;
        if (AWREADY) AWVALID <= 1'h0;
        if (WREADY) WVALID <= 1'h0;
        if (n > 2 && !(BVALID && BREADY)) BREADY <= 1'h1;
        if (n > 50) lost("write");
      end while (!(BVALID && BREADY));
      BREADY <= 1'h0;
      check("write response", er, BRESP);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    begin
      n = 0;
      ARADDR <= a;
      ARVALID <= 1'h1;
      do begin
        @(posedge CLK);
        n++;
        if (ARREADY) ARVALID <= 1'h0;
        if (n > 1 && !(RVALID && RREADY)) RREADY <= 1'h1;
        if (n > 50) lost("read");
      end while (!(RVALID && RREADY));
      d = RDATA;
      RREADY <= 1'h0;
      check("read response", er, RRESP);
    end
  endtask

  task automatic pulse(input int i);
    begin
      ev[i] <= 1'h1;
      @(posedge CLK);
      ev[i] <= 1'h0;
      repeat (3) @(posedge CLK);
    end
  endtask

  // Edges counted at the function clock; a wait with no rise is bounded
  task automatic next_rise(output int n);
    logic prev;
    begin
      n = 0;
      prev = CARD_CLOCK_PIN;
      do begin
        @(posedge CLK);
        n++;
        if (n > 300) lost("clock rise");
        if (CARD_CLOCK_PIN && !prev) break;
        prev = CARD_CLOCK_PIN;
      end while (1);
    end
  endtask

  task automatic t_reset_values;
    logic [31:0] d;
    begin
      rd(`MCS_OFF_CTRL, d);
      check("control reset", `MCS_RST_CTRL, d);
      rd(`MCS_OFF_CLK, d);
      check("clock reset", `MCS_RST_CLK, d);
      rd(`MCS_OFF_BLEN, d);
      check("block length reset", `MCS_RST_BLEN, d);
      rd(8'h3C, d, `MCS_RESP_SLVERR);
      wr(`MCS_OFF_STA, 32'h0, `MCS_RESP_SLVERR);
    end
  endtask

  task automatic t_control;
    logic [31:0] d;
    begin
      pulse(3);
      wr(`MCS_OFF_CTRL, 32'h4);
      repeat (2) @(posedge CLK);
      check("bus width four", 1'h1, BUS_4BIT);
      check("logic resets", 2'h0, {CMD_LOGIC_RESET, DATA_LOGIC_RESET});
      wr(`MCS_OFF_CTRL, 32'h0);
      repeat (2) @(posedge CLK);
      check("bus width one", 1'h0, BUS_4BIT);
      rd(`MCS_OFF_STA, d);
      check("flag while held", 1'h0, d[`MCS_ST_RESP_CRC_ERR]);
    end
  endtask

  task automatic t_divider;
    int k, p, r;
    begin
      for (k = 0; k < 3; k++) begin
        wr(`MCS_OFF_CLK, {22'h0, k[0], 1'h1, (k < 2) ? 8'h02 : 8'h00});
        next_rise(p);
        next_rise(p);
        check("memory clock period", (k == 1) ? 12 : (k == 0) ? 6 : 2, p);
      end
      wr(`MCS_OFF_CLK, 32'h2);
      for (k = 0; k < 2; k++) begin
        xfer <= k[0];
        repeat (10) @(posedge CLK);
        if (k[0]) next_rise(p);
        r = 0;
        repeat (60) @(posedge CLK) r = r + CARD_CLOCK_PIN;
        check("gated clock runs", k[0], r != 0);
      end
      xfer <= 1'h0;
      wr(`MCS_OFF_CLK, 32'h100);
    end
  endtask

  task automatic t_timeout(input logic [7:0] a, input int s, input int b);
    int n;
    logic [31:0] d;
    begin
      wr(`MCS_OFF_IM, 32'h1 << b);
      wr(a, 32'h4);
      ev[s] <= 1'h1;
      @(posedge CLK);
      ev[s] <= 1'h0;
      n = 0;
      do begin
        @(posedge CLK);
        n++;
        if (n > 40) lost("time-out");
      end while (!(b == 3 ? RESP_TIMEOUT : READ_TIMEOUT));
      check("time-out cycles", 1'h1, n >= 6 && n <= 12);
      repeat (2) @(posedge CLK);
      check("time-out irq", 1'h1, IRQ);
      rd(`MCS_OFF_STA, d);
      check("time-out flag", 1'h1, d[b]);
      repeat (2) @(posedge CLK);
      check("irq after status read", 1'h0, IRQ);
      rd(`MCS_OFF_STA, d);
      check("flag after status read", 1'h0, d[b]);
      wr(a, 32'h0);
      pulse(s);
      repeat (200) @(posedge CLK) if (RESP_TIMEOUT || READ_TIMEOUT) n = 0;
      check("zero limit waits", 1'h1, n != 0);
      pulse(s + 1);
    end
  endtask

  task automatic t_events;
    int k;
    logic [31:0] d;
    int evi [5] = '{3, 6, 7, 8, 1};
    int bt [5] = '{7, 6, 5, 0, 2};
    begin
      for (k = 0; k < 5; k++) begin
        wr(`MCS_OFF_IM, k[0] ? (32'h1 << bt[k]) : 32'h0);
        pulse(evi[k]);
        check("event irq", k[0], IRQ);
        rd(`MCS_OFF_STA, d);
        check("event flag", 1'h1, d[bt[k]]);
      end
    end
  endtask

  task automatic t_status;
    logic [31:0] d;
    begin
      busy_req <= 1'h1;
      txemp <= 1'h1;
      FIFO_LEVEL <= 8'h28;
      repeat (10) @(posedge CLK);
      rd(`MCS_OFF_STB, d);
      check("card busy", 2'h3, {d[`MCS_SB_BUSY], d[`MCS_SB_TXEMP]});
      rd(`MCS_OFF_STA, d);
      check("rx ready", 1'h1, d[`MCS_ST_RXRDY]);
      busy_req <= 1'h0;
      txemp <= 1'h0;
      FIFO_LEVEL <= 8'h00;
      xfer <= 1'h1;
      repeat (10) @(posedge CLK);
      rd(`MCS_OFF_STB, d);
      check("card idle", 2'h0, {d[`MCS_SB_BUSY], d[`MCS_SB_TXEMP]});
      rd(`MCS_OFF_RXD, d);
      rd(`MCS_OFF_STA, d);
      check("rx tx ready", 2'h1, {d[`MCS_ST_RXRDY], d[`MCS_ST_TXRDY]});
      wr(`MCS_OFF_TXD, 32'h5A5A5A5A);
      check("tx data", 32'h5A5A5A5A, FIFO_WDATA);
    end
  endtask

  // Two-byte blocks: one counted block, then an unlimited run
  task automatic t_blocks;
    logic [31:0] d;
    begin
      wr(`MCS_OFF_BLEN, 32'h2);
      wr(`MCS_OFF_NBLK, 32'h1);
      wr(`MCS_OFF_IM, 32'h1 << `MCS_ST_LAST);
      pulse(0);
      check("last block", 1'h1, XFER_LAST_BLOCK);
      pulse(9);
      check("early last byte", 1'h0, IRQ);
      pulse(9);
      check("last byte irq", 1'h1, IRQ);
      pulse(10);
      rd(`MCS_OFF_NBLC, d);
      check("blocks left", 32'h0, d);
      rd(`MCS_OFF_STA, d);
      check("last byte flag", 1'h1, d[`MCS_ST_LAST]);
      wr(`MCS_OFF_NBLK, 32'h0);
      pulse(0);
      pulse(9);
      pulse(9);
      check("unlimited count", 1'h0, XFER_LAST_BLOCK);
      rd(`MCS_OFF_STA, d);
      check("no last byte", 1'h0, d[`MCS_ST_LAST]);
    end
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge CLK);
    RESET <= 1'h0;
    @(posedge CLK);
    t_reset_values();
    t_control();
    t_divider();
    t_timeout(`MCS_OFF_TOR, 0, 3);
    t_timeout(`MCS_OFF_TOD, 4, 4);
    t_events();
    t_blocks();
    t_status();
    results();
  end
endmodule
`default_nettype wire
